// ==== hdl/key_mgmt_pkg.sv ====
// constants, types and register map of the encryption key manager
// assumes a single 20 MHz clock domain and a plain word-addressed register port
//
// Overview of operation
// - all bidirectional links of one unit share one entity and one unit-wide key
// - each multicast link maps to its own entity, so U units plus M multicasts
// - units receive on every provisioned link, transmit upstream only on bidirectional links
// - key switch covers all bidirectional links; channels may switch at different moments
// - each transmit channel has its own cipher instance before the outgoing envelope buffer
// - each cipher instance has a key activation part and a payload transform part
// - initial 128-bit key is the low 16 octets of the master session secret
// - terminal uses the initial key to protect the first session key delivery
// - the initial key is stored in slot 0 of the unit's entity
// - downstream cipher stays off until cipher clock sync is acknowledged
// - key in memory plus sync acknowledged sets first-key-ready; activation starts downstream
// - terminal makes later keys and sends them only over an encrypted management link
// - several next keys for one entity keep only the last one delivered
// - each entity has a lifetime timer; expiry activates the next key
// - next key is sent early enough that lost messages can be retried
// - key size is held per entity
// - one key-config message carries the key for all unicast links of a unit
// - missing acknowledgement within the reply timeout retries, at least 3 attempts
// - unit without the new key at expiry loses connectivity; flagged as critical
// - key index field is one bit, selecting one of two slots
// - after expiry the next header flips the key index and uses the new key
package key_mgmt_pkg;
    localparam int NUM_EE = 4;
    localparam int EE_W = 2;
    localparam int NUM_CH = 2;
    localparam int NUM_LINK = 8;
    localparam int LINK_W = 3;
    localparam int KEY_W = 128;
    localparam int SECRET_W = 256;
    localparam int ADDR_W = 5;
    // timing
    localparam longint CLK_HZ = 20000000;
    localparam longint REPLY_TIMEOUT_MS = 1000;
    localparam int REPLY_TIMEOUT_CYC = int'((REPLY_TIMEOUT_MS * CLK_HZ) / 1000);
    localparam logic [3:0] MIN_TRIES = 4'h3;
    // register word addresses
    localparam logic [ADDR_W-1:0] A_CTRL = 5'h00;
    localparam logic [ADDR_W-1:0] A_LIFE = 5'h01;
    localparam logic [ADDR_W-1:0] A_TRIES = 5'h02;
    localparam logic [ADDR_W-1:0] A_MAP = 5'h03;
    localparam logic [ADDR_W-1:0] A_STAGE0 = 5'h04;
    localparam logic [ADDR_W-1:0] A_KEYCMD = 5'h08;
    localparam logic [ADDR_W-1:0] A_STATUS = 5'h09;
    localparam logic [ADDR_W-1:0] A_DLSTAT = 5'h0a;
    // reset values
    localparam logic [31:0] LIFE_RST = 32'h0001_0000;
    localparam logic [3:0] TRIES_RST = 4'h3;
    // map entry: [3] valid, [2] bidirectional, [1:0] entity
    localparam int MAP_VALID = 3;
    localparam int MAP_BIDIR = 2;
    // status byte per entity
    localparam int ST_FIRST = 0;
    localparam int ST_NEXT = 1;
    localparam int ST_ACKED = 2;
    localparam int ST_RETRY_ERR = 3;
    localparam int ST_CRIT = 4;
    localparam int ST_ACT = 5;
    localparam int ST_SYNC = 6;
    localparam int ST_KEY0 = 7;

    typedef enum logic [1:0] {
        DL_IDLE = 2'b00,
        DL_SEND = 2'b01,
        DL_WAIT = 2'b11
    } dl_state_t;
endpackage

// ==== hdl/key_mgmt.sv ====
// line-terminal encryption key manager: key memory, activation and delivery
// assumes header requests, acks and strobes are synchronous to clk
//
// The register addresses and the plain strobed port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module key_mgmt import key_mgmt_pkg::*; #(
    parameter int REPLY_TIMEOUT_CYCLES = REPLY_TIMEOUT_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register port
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    // authentication result and cipher clock sync
    input wire logic auth_done,
    input wire logic [EE_W-1:0] auth_ee,
    input wire logic [SECRET_W-1:0] master_session_secret,
    input wire logic sync_ack_valid,
    input wire logic [EE_W-1:0] sync_ack_ee,
    // transmit channels
    input wire logic [NUM_CH-1:0] tx_hdr_valid,
    input wire logic [NUM_CH-1:0][LINK_W-1:0] tx_hdr_link,
    output logic [NUM_CH-1:0][KEY_W-1:0] tx_key,
    output logic [NUM_CH-1:0] tx_key_index_field,
    output logic [NUM_CH-1:0] tx_cipher_on_flag,
    output logic [NUM_CH-1:0][1:0] tx_key_size,
    output logic [NUM_CH-1:0] tx_link_ok,
    // receive channels
    input wire logic [NUM_CH-1:0] rx_hdr_valid,
    input wire logic [NUM_CH-1:0][LINK_W-1:0] rx_hdr_link,
    input wire logic [NUM_CH-1:0] rx_hdr_key_index,
    output logic [NUM_CH-1:0][KEY_W-1:0] rx_key,
    output logic [NUM_CH-1:0][1:0] rx_key_size,
    output logic [NUM_CH-1:0] rx_link_ok,
    // key delivery over the management link
    output logic key_config_action,
    output logic [EE_W-1:0] key_config_ee,
    output logic [KEY_W-1:0] key_config_key,
    output logic [1:0] key_config_size,
    input wire logic cfg_ack_valid,
    input wire logic [EE_W-1:0] cfg_ack_ee,
    input wire logic cfg_ack_ok,
    // events
    output logic retry_error,
    output logic critical_link
);

    typedef struct packed {
        // key memory, two slots per entity
        logic [NUM_EE-1:0][1:0][KEY_W-1:0] keys;
        logic [NUM_EE-1:0][1:0] ksize;
        logic [NUM_EE-1:0] key0_ok;
        logic [NUM_EE-1:0] sync_ok;
        logic [NUM_EE-1:0] first_ready;
        logic [NUM_EE-1:0] next_ok;
        logic [NUM_EE-1:0] acked;
        logic [NUM_EE-1:0] dl_req;
        logic [NUM_EE-1:0] act;
        logic [NUM_EE-1:0] rerr;
        logic [NUM_EE-1:0] crit;
        // per-channel slot select and pending flips
        logic [NUM_EE-1:0][NUM_CH-1:0] ch_idx;
        logic [NUM_EE-1:0][NUM_CH-1:0] pend;
        logic [NUM_EE-1:0][31:0] life_cnt;
        // software registers
        logic [NUM_LINK-1:0][3:0] map;
        logic [3:0][31:0] stage;
        logic [31:0] life;
        logic [3:0] tries;
        logic enable;
        // delivery engine
        dl_state_t dl;
        logic [EE_W-1:0] dl_ee;
        logic [3:0] try_cnt;
        logic [31:0] tmo;
        // registered outputs
        logic [31:0] rdata;
        logic [NUM_CH-1:0][KEY_W-1:0] txk;
        logic [NUM_CH-1:0] txi;
        logic [NUM_CH-1:0] txon;
        logic [NUM_CH-1:0][1:0] txs;
        logic [NUM_CH-1:0] txok;
        logic [NUM_CH-1:0][KEY_W-1:0] rxk;
        logic [NUM_CH-1:0][1:0] rxs;
        logic [NUM_CH-1:0] rxok;
        logic cfg_act;
        logic [KEY_W-1:0] cfg_key;
        logic [1:0] cfg_size;
        logic rerr_p;
        logic crit_p;
    } state_t;

    state_t s_r;
    state_t s_nxt;

    // entity of a link: unit links share their unit's entity, multicasts own one
    function automatic logic [EE_W-1:0] ee_of(input state_t s, input logic [LINK_W-1:0] l);
        ee_of = s.map[l][EE_W-1:0];
    endfunction

    function automatic logic [31:0] status_word(input state_t s);
        logic [31:0] w;
        w = 32'h0;
        // one byte per entity, entity 0 lowest
        for (int e = 0; e < NUM_EE; e++) begin
            w[e*8+ST_FIRST] = s.first_ready[e];
            w[e*8+ST_NEXT] = s.next_ok[e];
            w[e*8+ST_ACKED] = s.acked[e];
            w[e*8+ST_RETRY_ERR] = s.rerr[e];
            w[e*8+ST_CRIT] = s.crit[e];
            w[e*8+ST_ACT] = s.act[e];
            w[e*8+ST_SYNC] = s.sync_ok[e];
            w[e*8+ST_KEY0] = s.key0_ok[e];
        end
        status_word = w;
    endfunction

    // next state of the whole block
    always_comb begin
        logic [EE_W-1:0] e;
        logic [EE_W-1:0] ce;
        logic idx;
        logic expired;
        s_nxt = s_r;
        e = '0;
        ce = '0;
        idx = 1'b0;
        expired = 1'b0;
        // pulses and read data default low each cycle
        s_nxt.cfg_act = 1'b0;
        s_nxt.rerr_p = 1'b0;
        s_nxt.crit_p = 1'b0;
        s_nxt.rdata = 32'h0;

        // register reads: data valid the cycle after the strobe only
        if (rd) begin
            case (addr)
                A_CTRL: s_nxt.rdata = {31'h0, s_r.enable};
                A_LIFE: s_nxt.rdata = s_r.life;
                A_TRIES: s_nxt.rdata = {28'h0, s_r.tries};
                A_MAP: s_nxt.rdata = s_r.map;
                A_STATUS: s_nxt.rdata = status_word(s_r);
                A_DLSTAT: s_nxt.rdata = {20'h0, s_r.try_cnt, 2'h0, s_r.dl_ee, 2'h0, s_r.dl};
                default: begin
                    if (addr >= A_STAGE0 && addr < A_KEYCMD) begin
                        s_nxt.rdata = s_r.stage[addr[1:0]];
                    end
                end
            endcase
        end

        // register writes
        if (wr) begin
            case (addr)
                A_CTRL: s_nxt.enable = wdata[0];
                A_LIFE: s_nxt.life = wdata;
                // attempt limit never goes below three
                A_TRIES: s_nxt.tries = (wdata[3:0] < MIN_TRIES) ? MIN_TRIES : wdata[3:0];
                A_MAP: s_nxt.map[wdata[LINK_W-1:0]] = wdata[7:4];
                A_KEYCMD: begin
                    // staged words land in the idle slot in one cycle
                    e = wdata[EE_W-1:0];
                    s_nxt.keys[e][~s_r.act[e]] = s_r.stage;
                    s_nxt.ksize[e] = wdata[5:4];
                    s_nxt.next_ok[e] = 1'b1;
                    s_nxt.acked[e] = 1'b0;
                    s_nxt.dl_req[e] = 1'b1;
                end
                A_STATUS: begin
                    // write one to clear; a same-cycle event below wins
                    for (int k = 0; k < NUM_EE; k++) begin
                        if (wdata[k*8+ST_RETRY_ERR]) s_nxt.rerr[k] = 1'b0;
                        if (wdata[k*8+ST_CRIT]) s_nxt.crit[k] = 1'b0;
                    end
                end
                default: begin
                    if (addr >= A_STAGE0 && addr < A_KEYCMD) begin
                        s_nxt.stage[addr[1:0]] = wdata;
                    end
                end
            endcase
        end

        // initial key from the low 16 octets of the master secret, slot 0
        if (auth_done) begin
            s_nxt.keys[auth_ee][0] = master_session_secret[KEY_W-1:0];
            s_nxt.key0_ok[auth_ee] = 1'b1;
            s_nxt.act[auth_ee] = 1'b0;
            s_nxt.ch_idx[auth_ee] = '0;
            s_nxt.pend[auth_ee] = '0;
        end

        // sync acks are sticky until reset
        if (sync_ack_valid) begin
            s_nxt.sync_ok[sync_ack_ee] = 1'b1;
        end

        // transmit: one activation/cipher-select instance per channel
        for (int c = 0; c < NUM_CH; c++) begin
            e = ee_of(s_r, tx_hdr_link[c]);
            idx = s_r.ch_idx[e][c];
            if (tx_hdr_valid[c]) begin
                // first header after expiry flips the index on this channel only
                if (s_r.pend[e][c]) begin
                    idx = ~idx;
                    s_nxt.ch_idx[e][c] = idx;
                    s_nxt.pend[e][c] = 1'b0;
                end
                s_nxt.txk[c] = s_r.keys[e][idx];
                s_nxt.txi[c] = idx;
                s_nxt.txs[c] = s_r.ksize[e];
                s_nxt.txon[c] = s_r.enable & s_r.first_ready[e];
                s_nxt.txok[c] = s_r.map[tx_hdr_link[c]][MAP_VALID]
                    & s_r.map[tx_hdr_link[c]][MAP_BIDIR];
            end
            // receive: key chosen by entity and the header's index bit
            e = ee_of(s_r, rx_hdr_link[c]);
            if (rx_hdr_valid[c]) begin
                s_nxt.rxk[c] = s_r.keys[e][rx_hdr_key_index[c]];
                s_nxt.rxs[c] = s_r.ksize[e];
                s_nxt.rxok[c] = s_r.map[rx_hdr_link[c]][MAP_VALID];
            end
        end

        // readiness and lifetime timers per entity
        for (int k = 0; k < NUM_EE; k++) begin
            if (s_r.key0_ok[k] && s_r.sync_ok[k] && !s_r.first_ready[k]) begin
                s_nxt.first_ready[k] = 1'b1;
                s_nxt.life_cnt[k] = s_r.life;
            end else if (s_r.first_ready[k]) begin
                // the timer reloads at every expiry, switch or not
                expired = (s_r.life_cnt[k] <= 32'h1);
                s_nxt.life_cnt[k] = expired ? s_r.life : s_r.life_cnt[k] - 32'h1;
                if (expired) begin
                    // the switch goes ahead if a next key is stored; a unit without the key falls off the link
                    if (s_r.next_ok[k]) begin
                        s_nxt.act[k] = ~s_r.act[k];
                        s_nxt.pend[k] = '1;
                        s_nxt.next_ok[k] = 1'b0;
                    end
                    if (!s_r.acked[k] || !s_r.next_ok[k]) begin
                        s_nxt.crit[k] = 1'b1;
                        s_nxt.crit_p = 1'b1;
                    end
                    s_nxt.acked[k] = 1'b0;
                end
            end
        end

        // key delivery with retries
        // one delivery in flight; other entities queue behind it
        case (s_r.dl)
            DL_IDLE: begin
                // only entities already ciphered may carry a new key
                for (int k = NUM_EE - 1; k >= 0; k--) begin
                    if (s_r.dl_req[k] && s_r.first_ready[k]) begin
                        s_nxt.dl_ee = EE_W'(k);
                        s_nxt.dl = DL_SEND;
                        s_nxt.try_cnt = 4'h0;
                    end
                end
            end
            DL_SEND: begin
                // each attempt restarts the reply timer
                ce = s_r.dl_ee;
                s_nxt.cfg_act = 1'b1;
                s_nxt.cfg_key = s_r.keys[ce][~s_r.act[ce]];
                s_nxt.cfg_size = s_r.ksize[ce];
                s_nxt.dl_req[ce] = (wr && addr == A_KEYCMD && wdata[EE_W-1:0] == ce);
                s_nxt.try_cnt = s_r.try_cnt + 4'h1;
                s_nxt.tmo = 32'(REPLY_TIMEOUT_CYCLES);
                s_nxt.dl = DL_WAIT;
            end
            DL_WAIT: begin
                // a nack and a silent peer each cost one attempt
                ce = s_r.dl_ee;
                s_nxt.tmo = s_r.tmo - 32'h1;
                if (cfg_ack_valid && cfg_ack_ee == ce && cfg_ack_ok) begin
                    s_nxt.acked[ce] = ~s_nxt.dl_req[ce];
                    s_nxt.dl = DL_IDLE;
                end else if ((cfg_ack_valid && cfg_ack_ee == ce) || s_r.tmo <= 32'h1) begin
                    if (s_r.try_cnt >= s_r.tries) begin
                        s_nxt.rerr[ce] = 1'b1;
                        s_nxt.rerr_p = 1'b1;
                        s_nxt.dl = DL_IDLE;
                    end else begin
                        s_nxt.dl = DL_SEND;
                    end
                end
            end
            default: s_nxt.dl = DL_IDLE;
        endcase
    end

    // single state register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            // registers start from their defaults
            s_r <= '0;
            s_r.life <= LIFE_RST;
            s_r.tries <= TRIES_RST;
            s_r.dl <= DL_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from the state register
    // an unmapped link reads entity 0 keys but shows link_ok low
    assign rdata = s_r.rdata;
    assign tx_key = s_r.txk;
    assign tx_key_index_field = s_r.txi;
    assign tx_cipher_on_flag = s_r.txon;
    assign tx_key_size = s_r.txs;
    assign tx_link_ok = s_r.txok;
    assign rx_key = s_r.rxk;
    assign rx_key_size = s_r.rxs;
    assign rx_link_ok = s_r.rxok;
    assign key_config_action = s_r.cfg_act;
    assign key_config_ee = s_r.dl_ee;
    assign key_config_key = s_r.cfg_key;
    assign key_config_size = s_r.cfg_size;
    assign retry_error = s_r.rerr_p;
    assign critical_link = s_r.crit_p;

    // checks
    a_ready_cause: assert property (@(posedge clk) disable iff (rst)
        (s_r.first_ready & ~$past(s_r.first_ready) & ~$past(s_r.key0_ok & s_r.sync_ok)) == '0)
        else $error("first key ready without key or sync");

    a_cipher_off_nosync: assert property (@(posedge clk) disable iff (rst)
        tx_cipher_on_flag[0] |-> $past(s_r.sync_ok[s_r.map[tx_hdr_link[0]][EE_W-1:0]], 2)
            || $past(s_r.first_ready[s_r.map[tx_hdr_link[0]][EE_W-1:0]]))
        else $error("cipher on before sync");

    a_init_slot0: assert property (@(posedge clk) disable iff (rst)
        auth_done |=> s_r.keys[$past(auth_ee)][0] == $past(master_session_secret[KEY_W-1:0]))
        else $error("initial key not in slot 0");

    a_tries_floor: assert property (@(posedge clk) disable iff (rst)
        s_r.tries >= MIN_TRIES)
        else $error("attempt limit below three");

    a_send_encrypted: assert property (@(posedge clk) disable iff (rst)
        key_config_action |-> s_r.first_ready[s_r.dl_ee])
        else $error("key sent on unciphered link");

    a_send_to_wait: assert property (@(posedge clk) disable iff (rst)
        s_r.dl == DL_SEND |=> key_config_action && s_r.dl == DL_WAIT)
        else $error("delivery not issued");

    a_retry_bound: assert property (@(posedge clk) disable iff (rst)
        retry_error |-> $past(s_r.try_cnt) >= $past(s_r.tries))
        else $error("error before attempts used");

    a_upstream_bidir: assert property (@(posedge clk) disable iff (rst)
        tx_hdr_valid[1] && !s_r.map[tx_hdr_link[1]][MAP_BIDIR] |=> !tx_link_ok[1])
        else $error("upstream on unidirectional link");

    a_flip_pending: assert property (@(posedge clk) disable iff (rst)
        tx_hdr_valid[0] && s_r.pend[s_r.map[tx_hdr_link[0]][EE_W-1:0]][0]
        |=> tx_key_index_field[0] != $past(s_r.ch_idx[s_r.map[tx_hdr_link[0]][EE_W-1:0]][0]))
        else $error("index not flipped after expiry");

    // scenarios that should be reached
    c_first_ready: cover property (@(posedge clk) disable iff (rst) $rose(|s_r.first_ready));
    c_delivery: cover property (@(posedge clk) disable iff (rst) key_config_action);
    c_retry_err: cover property (@(posedge clk) disable iff (rst) retry_error);
    c_flip: cover property (@(posedge clk) disable iff (rst) $changed(tx_key_index_field[0]));

endmodule // key_mgmt
`default_nettype wire

// ==== verification/onu_peer_model.sv ====
// subscriber-unit side of the key delivery exchange: answers each key message
// assumes key_config_action is a one-cycle pulse synchronous to clk
`timescale 1ns/10ps
`default_nettype none
module onu_peer_model import key_mgmt_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // key message from the terminal
    input wire logic key_config_action,
    input wire logic [EE_W-1:0] key_config_ee,
    // 0 answers with an ack, 1 stays silent so the terminal must retry
    input wire logic silent,
    // response message
    output logic cfg_ack_valid,
    output logic [EE_W-1:0] cfg_ack_ee,
    output logic cfg_ack_ok
);
    logic [2:0] dly_r;
    logic [EE_W-1:0] ee_r;
    // answer four cycles after the request; idle lines toggle so nothing stale looks valid
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dly_r <= 3'h0;
            ee_r <= 2'h0;
            cfg_ack_valid <= 1'b0;
            cfg_ack_ee <= 2'h0;
            cfg_ack_ok <= 1'b0;
        end else begin
            cfg_ack_valid <= 1'b0;
            cfg_ack_ee <= ~cfg_ack_ee;
            cfg_ack_ok <= ~cfg_ack_ok;
            dly_r <= (dly_r != 3'h0) ? dly_r - 3'h1 : 3'h0;
            if (key_config_action && !silent) begin
                dly_r <= 3'h3;
                ee_r <= key_config_ee;
            end
            if (dly_r == 3'h1) begin
                cfg_ack_valid <= 1'b1;
                cfg_ack_ee <= ee_r;
                cfg_ack_ok <= 1'b1;
            end
        end
    end
endmodule // onu_peer_model
`default_nettype wire

// ==== verification/testbench.sv ====
// self-checking bench for the key manager with a subscriber-unit peer
// assumes the reply timeout parameter is shortened to 20 cycles
`timescale 1ns/10ps
`default_nettype none
module testbench import key_mgmt_pkg::*;;
    logic clk, rst, wr, rd, auth_done, sync_ack_valid, silent;
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata, rdata;
    logic [EE_W-1:0] auth_ee, sync_ack_ee, key_config_ee, cfg_ack_ee;
    logic [SECRET_W-1:0] secret;
    logic [NUM_CH-1:0] tx_hdr_valid, rx_hdr_valid, rx_hdr_key_index, tx_idx, tx_on, tx_ok, rx_ok;
    logic [NUM_CH-1:0][LINK_W-1:0] tx_hdr_link, rx_hdr_link;
    logic [NUM_CH-1:0][KEY_W-1:0] tx_key, rx_key;
    logic [NUM_CH-1:0][1:0] tx_size, rx_size;
    logic key_config_action, cfg_ack_valid, cfg_ack_ok, retry_error, critical_link;
    logic [KEY_W-1:0] key_config_key;
    logic [1:0] key_config_size;
    int n_mismatch, checked, n_act;
    key_mgmt #(.REPLY_TIMEOUT_CYCLES(20)) dut (.clk(clk), .rst(rst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .auth_done(auth_done),
        .auth_ee(auth_ee), .master_session_secret(secret), .sync_ack_valid(sync_ack_valid),
        .sync_ack_ee(sync_ack_ee), .tx_hdr_valid(tx_hdr_valid), .tx_hdr_link(tx_hdr_link),
        .tx_key(tx_key), .tx_key_index_field(tx_idx), .tx_cipher_on_flag(tx_on),
        .tx_key_size(tx_size), .tx_link_ok(tx_ok), .rx_hdr_valid(rx_hdr_valid),
        .rx_hdr_link(rx_hdr_link), .rx_hdr_key_index(rx_hdr_key_index), .rx_key(rx_key),
        .rx_key_size(rx_size), .rx_link_ok(rx_ok), .key_config_action(key_config_action),
        .key_config_ee(key_config_ee), .key_config_key(key_config_key),
        .key_config_size(key_config_size), .cfg_ack_valid(cfg_ack_valid),
        .cfg_ack_ee(cfg_ack_ee), .cfg_ack_ok(cfg_ack_ok), .retry_error(retry_error),
        .critical_link(critical_link));
    onu_peer_model peer (.clk(clk), .rst(rst), .key_config_action(key_config_action),
        .key_config_ee(key_config_ee), .silent(silent), .cfg_ack_valid(cfg_ack_valid),
        .cfg_ack_ee(cfg_ack_ee), .cfg_ack_ok(cfg_ack_ok));
    // clock generator
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // count key messages so the retry scenario can judge the attempt total
    always @(posedge clk) if (key_config_action === 1'b1) n_act++;
    task automatic chk(input string what, input logic [KEY_W-1:0] exp, got);
        checked++;
        if (exp !== got) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    // one header on a channel in both directions; outputs settle after the next edge
    task automatic hdr(input int c, input logic [LINK_W-1:0] l, input logic ki);
        @(posedge clk);
        tx_hdr_valid[c] <= 1'b1;
        tx_hdr_link[c] <= l;
        rx_hdr_valid[c] <= 1'b1;
        rx_hdr_link[c] <= l;
        rx_hdr_key_index[c] <= ki;
        @(posedge clk);
        tx_hdr_valid[c] <= 1'b0;
        rx_hdr_valid[c] <= 1'b0;
        #1;
    endtask
    task automatic commit_key(input logic [KEY_W-1:0] k);
        for (int i = 0; i < 4; i++) wr_reg(A_STAGE0 + 5'(i), k[32*i +: 32]);
        wr_reg(A_KEYCMD, 32'h0000_0011); // entity 1, size code 1
    endtask
    task automatic t_reset_values();
        logic [31:0] d;
        rd_reg(A_LIFE, d);
        chk("life reset", 128'(LIFE_RST), 128'(d));
        rd_reg(A_TRIES, d);
        chk("tries reset", 128'(TRIES_RST), 128'(d));
        rd_reg(5'h1f, d);
        chk("unmapped read", 128'h0, 128'(d));
    endtask
    // initial key from the low secret half, held off until clock sync is acknowledged
    task automatic t_initial_key();
        logic [31:0] d;
        wr_reg(A_LIFE, 32'h0000_0190);
        wr_reg(A_MAP, 32'h0000_00d0); // link 0: valid, bidir, entity 1
        wr_reg(A_MAP, 32'h0000_0091); // link 1: valid, receive only, entity 1
        wr_reg(A_CTRL, 32'h0000_0001);
        rd_reg(A_MAP, d);
        chk("map read", 128'h9d, 128'(d));
        @(posedge clk);
        auth_done <= 1'b1;
        auth_ee <= 2'h1;
        @(posedge clk);
        auth_done <= 1'b0;
        hdr(0, 3'h0, 1'b0);
        chk("cipher before sync", 128'h0, 128'(tx_on[0]));
        @(posedge clk);
        sync_ack_valid <= 1'b1;
        sync_ack_ee <= 2'h1;
        @(posedge clk);
        sync_ack_valid <= 1'b0;
        repeat (2) @(posedge clk);
        rd_reg(A_STATUS, d);
        chk("first ready", 128'h1, 128'(d[8]));
        hdr(0, 3'h0, 1'b0);
        chk("cipher on", 128'h1, 128'(tx_on[0]));
        chk("tx initial key", secret[127:0], tx_key[0]);
        chk("rx initial key", secret[127:0], rx_key[0]);
        chk("index slot 0", 128'h0, 128'(tx_idx[0]));
        hdr(1, 3'h1, 1'b0);
        chk("tx on receive-only", 128'h0, 128'(tx_ok[1]));
        chk("rx on receive-only", 128'h1, 128'(rx_ok[1]));
        hdr(1, 3'h5, 1'b0);
        chk("unmapped link", 128'h0, 128'({tx_ok[1], rx_ok[1]}));
    endtask
    // two keys back to back: both travel in turn, the later one overwrites the idle slot and is activated at expiry
    task automatic t_next_key();
        logic [31:0] d;
        commit_key({4{32'h1111_2222}});
        commit_key({4{32'ha5a5_5a5a}});
        repeat (40) @(posedge clk);
        #1 chk("delivered key", {4{32'ha5a5_5a5a}}, key_config_key);
        chk("delivered size", 128'h1, 128'(key_config_size));
        chk("delivered entity", 128'h1, 128'(key_config_ee));
        rd_reg(A_STATUS, d);
        chk("acked", 128'h1, 128'(d[10]));
        for (int i = 0; i < 300 && tx_idx[0] !== 1'b1; i++) hdr(0, 3'h0, 1'b0);
        chk("index flip", 128'h1, 128'(tx_idx[0]));
        chk("new tx key", {4{32'ha5a5_5a5a}}, tx_key[0]);
        chk("new key size", 128'h1, 128'(tx_size[0]));
        hdr(1, 3'h0, 1'b1);
        chk("channel 1 flip", 128'h1, 128'(tx_idx[1]));
        chk("rx slot 1 key", {4{32'ha5a5_5a5a}}, rx_key[1]);
        chk("rx key size", 128'h1, 128'(rx_size[1]));
    endtask
    // silent peer: three attempts, error event, then critical condition at expiry
    task automatic t_retry();
        logic [31:0] d;
        int seen;
        silent <= 1'b1;
        wr_reg(A_TRIES, 32'h0000_0002);
        rd_reg(A_TRIES, d);
        chk("tries floor", 128'h3, 128'(d));
        n_act = 0;
        seen = 0;
        commit_key({4{32'h0f0f_3c3c}});
        for (int i = 0; i < 300 && seen == 0; i++) @(posedge clk) #1 seen = int'(retry_error);
        chk("retry error", 128'h1, 128'(seen));
        chk("attempts", 128'h3, 128'(n_act));
        rd_reg(A_DLSTAT, d);
        chk("delivery status", 128'h310, 128'(d));
        seen = 0;
        for (int i = 0; i < 500 && seen == 0; i++) @(posedge clk) #1 seen = int'(critical_link);
        chk("critical link", 128'h1, 128'(seen));
        rd_reg(A_STATUS, d);
        chk("error flags", 128'h3, 128'(d[12:11]));
        wr_reg(A_STATUS, 32'h0000_1800);
        rd_reg(A_STATUS, d);
        chk("flags cleared", 128'h0, 128'(d[12:11]));
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // watchdog sized well above the expected run length
    initial begin
        #(50 * 20000);
        n_mismatch++;
        stop_test();
    end
    initial begin
        n_mismatch = 0;
        checked = 0;
        {wr, rd, auth_done, sync_ack_valid, silent} = 5'h0;
        addr = 5'h0;
        wdata = 32'h0;
        auth_ee = 2'h0;
        sync_ack_ee = 2'h0;
        secret = {128'hdead_beef_0000_1111_2222_3333_4444_5555,
                  128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210};
        {tx_hdr_valid, rx_hdr_valid, rx_hdr_key_index} = 6'h0;
        tx_hdr_link = 6'h0;
        rx_hdr_link = 6'h0;
        rst = 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        t_reset_values();
        t_initial_key();
        t_next_key();
        t_retry();
        stop_test();
    end
endmodule // testbench
`default_nettype wire
